// >>> bench/lba_top_bench.sv
// self-checking apb bench for the leaky bucket activity alarm
module lba_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import lba_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int CYC = 20; // shortened observation cycle in clocks
    logic        clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err_seen;
    logic        input_fault;
    logic        alarm;
    logic        irq;
    int          mismatches;
    int          checks;
    int          clk_cnt = 0;
    int          t0;
    int          t1;

    lba_top #(.CYCLE_LEN(CYC)) dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .input_fault(input_fault), .alarm(alarm), .irq(irq));

    // 25 MHz clock and a free cycle counter for interval timing
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) clk_cnt <= clk_cnt + 1;
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    // the register index becomes a word-aligned byte address
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {a[9:0], 2'h0};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd       = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // poll the accumulator until it moves, noting the clock count
    task automatic wait_acc_change(output int t);
        logic [7:0] a0;
        apb(1'b0, ADDR_STATE, 32'h0);
        a0 = rd[7:0];
        do
            apb(1'b0, ADDR_STATE, 32'h0);
        while (rd[7:0] === a0);
        t = clk_cnt;
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, input_fault, reset_n} = '0;
        mismatches = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, access kinds and an unmapped address
        rdchk(ADDR_UPPER, {24'h0, RST_UPPER});
        rdchk(ADDR_LOWER, 32'h0000_0004);
        rdchk(ADDR_LIMIT, 32'h0000_0008);
        rdchk(ADDR_DECAY, 32'h0000_0001);
        rdchk(ADDR_STATE, 32'h0000_0000);
        check(irq, 1'b0);
        apb(1'b1, ADDR_LIMIT, 32'h0000_00AA);
        rdchk(ADDR_LIMIT, 32'h0000_00AA);
        check(err_seen, 1'b0);
        apb(1'b1, ADDR_LIMIT, 32'h0000_0008);
        apb(1'b0, 12'h070, 32'h0);
        check(err_seen, 1'b1);
        check(rd, 32'h0);
        check(pready, 1'b1);
        $display("test registers done");
        // fill until the alarm rises, then saturate
        apb(1'b1, ADDR_DECAY, 32'h0);
        apb(1'b1, ADDR_INT_EN, 32'h1);
        input_fault <= 1'b1;
        while (alarm !== 1'b1)
            @(posedge clk);
        rdchk(ADDR_STATE, 32'h0001_0006);
        check(alarm, 1'b1);
        check(irq, 1'b1);
        rdchk(ADDR_STATUS, 32'h0000_0005);
        repeat (12 * CYC) @(posedge clk);
        rdchk(ADDR_STATE, 32'h0001_0008);
        // clear the raise event, then unmask the pending fault event
        apb(1'b1, ADDR_INT_CLR, 32'h1);
        check(irq, 1'b0);
        apb(1'b1, ADDR_INT_EN, 32'h4);
        check(irq, 1'b1);
        // drain until the alarm falls at the lower level
        input_fault <= 1'b0;
        while (alarm !== 1'b0)
            @(posedge clk);
        rdchk(ADDR_STATE, 32'h0000_0004);
        check(alarm, 1'b0);
        rdchk(ADDR_STATUS, 32'h0000_0006);
        apb(1'b1, ADDR_INT_CLR, 32'h7);
        check(irq, 1'b0);
        rdchk(ADDR_STATUS, 32'h0000_0000);
        $display("test alarm done");
        // decrement spacing for every decay selector
        for (int d = 0; d < 4; d++)
        begin
            input_fault <= 1'b1;
            repeat (10 * CYC) @(posedge clk);
            input_fault <= 1'b0;
            apb(1'b1, ADDR_DECAY, 32'(d));
            wait_acc_change(t0);
            wait_acc_change(t1);
            check((t1 - t0 >= (CYC << d) - 3) && (t1 - t0 <= (CYC << d) + 3), 1'b1);
        end
        $display("test decay done");
        // a reset in mid-run brings back the defaults and an empty bucket
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        check(alarm, 1'b0);
        rdchk(ADDR_DECAY, {30'h0, RST_DECAY});
        rdchk(ADDR_STATE, 32'h0000_0000);
        $display("test reset done");
        report_and_stop();
    end
    // watchdog against a hung wait
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // lba_top_bench

// >>> rtl/lba_pkg.sv
// package for the leaky bucket activity alarm: register map, resets, timing
package lba_pkg;
    // ----------------------------------------------------------------
    // register indices: each register is one aligned word at four times its index
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_UPPER   = 12'h058;
    localparam logic [11:0] ADDR_LOWER   = 12'h059;
    localparam logic [11:0] ADDR_LIMIT   = 12'h05A;
    localparam logic [11:0] ADDR_DECAY   = 12'h05B;
    localparam logic [11:0] ADDR_STATUS  = 12'h060;
    localparam logic [11:0] ADDR_INT_EN  = 12'h064;
    localparam logic [11:0] ADDR_INT_CLR = 12'h068;
    localparam logic [11:0] ADDR_STATE   = 12'h06C;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_UPPER = 8'h06;
    localparam logic [7:0] RST_LOWER = 8'h04;
    localparam logic [7:0] RST_LIMIT = 8'h08;
    localparam logic [1:0] RST_DECAY = 2'h1;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CYCLE_MS   = 128;
    localparam int CLK_KHZ    = 25000;
    localparam int CYCLE_CLKS = CYCLE_MS * CLK_KHZ;
    // status bit positions
    localparam int ST_RAISE = 0;
    localparam int ST_CLEAR = 1;
    localparam int ST_FAIL  = 2;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] limit;
        logic [1:0] decay;
    } lba_cfg_s;

    typedef struct packed {
        lba_cfg_s   cfg;
        logic [2:0] int_en;
        logic [2:0] status;
        logic [7:0] acc;
        logic       alarm;
        logic [2:0] clean;
        logic       bad;
        logic [31:0] tick;
        logic [2:0] pin_sync;
        logic       fault;
        logic [31:0] prdata;
    } lba_state_s;
endpackage : lba_pkg

// >>> rtl/lba_top.sv
// leaky bucket activity alarm with apb register access
// Operation
// (RQ1) Observe input over fixed 128 ms cycles, noting any failure in each.
// (RQ2) Each cycle with a failure raises the accumulator by one.
// (RQ3) Each run of 1/2/4/8 clean cycles lowers the accumulator by one.
// (RQ4) Clear raised alarm when accumulator falls to lower threshold, default 4.
// (RQ5) Accumulator saturates at bucket limit, default 8.
// (RQ6) Raise alarm when accumulator reaches upper threshold, default 6.
// (RQ7) Decay selector 00/01/10/11 picks 1/2/4/8 clean cycles.
// (RQ8) Alarm has hysteresis between upper and lower thresholds.
module lba_top
    import lba_pkg::*;
#(
    parameter int CYCLE_LEN = lba_pkg::CYCLE_CLKS
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // monitored input fault indication (asynchronous)
    input  wire logic        input_fault,
    // alarm and interrupt
    output logic             alarm,
    output logic             irq
);
    import lba_pkg::*;

    // ----------------------------------------------------------------
    // reset synchroniser
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // release reset through two flops
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // clean cycles per decrement, minus one, from the decay selector
    function automatic logic [2:0] decay_len(input logic [1:0] sel);
        case (sel)
            2'h0:    decay_len = 3'h0;
            2'h1:    decay_len = 3'h1;
            2'h2:    decay_len = 3'h3;
            default: decay_len = 3'h7;
        endcase
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == ADDR_UPPER) || (a == ADDR_LOWER) || (a == ADDR_LIMIT) ||
                 (a == ADDR_DECAY) || (a == ADDR_STATUS) || (a == ADDR_INT_EN) ||
                 (a == ADDR_INT_CLR) || (a == ADDR_STATE);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    lba_state_s s_q;
    lba_state_s s_d;
    logic       wr;
    logic       rd;
    logic       cyc_end;
    logic       fault_seen;
    logic [2:0] ev;
    logic [11:0] reg_idx;
    logic        aligned;

    // word decode: a byte address off a word boundary maps to nothing
    assign reg_idx = {2'h0, paddr[11:2]};
    assign aligned = (paddr[1:0] == 2'h0);
    assign wr      = psel && penable && pwrite && aligned;
    assign rd      = psel && !penable && !pwrite;
    assign cyc_end = (s_q.tick == 32'(CYCLE_LEN - 1));
    assign fault_seen = s_q.bad || s_q.fault;

    // next-state logic
    always_comb
    begin
        s_d = s_q;
        ev  = 3'h0;
        // input sync: change counts when stages two and three agree
        s_d.pin_sync = {s_q.pin_sync[1:0], input_fault};
        if (s_q.pin_sync[2] == s_q.pin_sync[1])
            s_d.fault = s_q.pin_sync[2];
        // observation cycle timer and failure memory
        s_d.tick = cyc_end ? 32'h0 : s_q.tick + 32'h1;                 // RQ1
        s_d.bad  = cyc_end ? 1'b0 : fault_seen;                         // RQ1
        if (cyc_end)
        begin
            if (fault_seen)
            begin
                ev[ST_FAIL] = 1'b1;
                s_d.clean   = 3'h0;
                if (s_q.acc < s_q.cfg.limit)
                    s_d.acc = s_q.acc + 8'h1;                           // RQ2 RQ5
                else
                    s_d.acc = s_q.cfg.limit;                            // RQ5
            end
            else if (s_q.clean >= decay_len(s_q.cfg.decay))
            begin
                s_d.clean = 3'h0;                                       // RQ7
                if (s_q.acc != 8'h0)
                    s_d.acc = s_q.acc - 8'h1;                           // RQ3
            end
            else
                s_d.clean = s_q.clean + 3'h1;                           // RQ3
        end
        // alarm with hysteresis
        if (!s_q.alarm && s_d.acc >= s_q.cfg.upper)
        begin
            s_d.alarm      = 1'b1;                                      // RQ6 RQ8
            ev[ST_RAISE]   = 1'b1;
        end
        else if (s_q.alarm && s_d.acc <= s_q.cfg.lower)
        begin
            s_d.alarm      = 1'b0;                                      // RQ4 RQ8
            ev[ST_CLEAR]   = 1'b1;
        end
        // register writes
        if (wr)
        begin
            case (reg_idx)
                ADDR_UPPER:   s_d.cfg.upper = pwdata[7:0];
                ADDR_LOWER:   s_d.cfg.lower = pwdata[7:0];              // RQ4
                ADDR_LIMIT:   s_d.cfg.limit = pwdata[7:0];              // RQ5
                ADDR_DECAY:   s_d.cfg.decay = pwdata[1:0];              // RQ7
                ADDR_INT_EN:  s_d.int_en    = pwdata[2:0];
                default:      ;
            endcase
        end
        // sticky status: set wins over clear
        if (wr && reg_idx == ADDR_INT_CLR)
            s_d.status = (s_q.status & ~pwdata[2:0]) | ev;
        else
            s_d.status = s_q.status | ev;
        // read data captured in setup phase
        if (rd)
        begin
            case (reg_idx)
                ADDR_UPPER:  s_d.prdata = {24'h0, s_q.cfg.upper};
                ADDR_LOWER:  s_d.prdata = {24'h0, s_q.cfg.lower};
                ADDR_LIMIT:  s_d.prdata = {24'h0, s_q.cfg.limit};
                ADDR_DECAY:  s_d.prdata = {30'h0, s_q.cfg.decay};
                ADDR_STATUS: s_d.prdata = {29'h0, s_q.status};
                ADDR_INT_EN: s_d.prdata = {29'h0, s_q.int_en};
                ADDR_STATE:  s_d.prdata = {15'h0, s_q.alarm, 8'h0, s_q.acc};
                default:     s_d.prdata = 32'h0;
            endcase
            // unaligned reads return zero like unmapped ones
            if (!aligned)
                s_d.prdata = 32'h0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q           <= '0;
            s_q.cfg.upper <= RST_UPPER;
            s_q.cfg.lower <= RST_LOWER;
            s_q.cfg.limit <= RST_LIMIT;
            s_q.cfg.decay <= RST_DECAY;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata  = s_q.prdata;
    assign pready  = 1'b1;                       // every access ends in one cycle
    assign pslverr = psel && penable && !(aligned && mapped(reg_idx));
    assign alarm   = s_q.alarm;
    assign irq     = |(s_q.status & s_q.int_en);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_rq2_inc;
        @(posedge clk) disable iff (!rst_n)
        (cyc_end && fault_seen && s_q.acc < s_q.cfg.limit && !wr) |=> (s_q.acc == $past(s_q.acc) + 8'h1);
    endproperty
    a_rq2_inc: assert property (p_rq2_inc) else $error("accumulator did not rise"); // RQ2

    property p_rq5_cap;
        @(posedge clk) disable iff (!rst_n)
        (cyc_end && fault_seen && s_q.acc >= s_q.cfg.limit) |=> (s_q.acc == $past(s_q.cfg.limit));
    endproperty
    a_rq5_cap: assert property (p_rq5_cap) else $error("accumulator passed limit"); // RQ5

    property p_rq3_dec;
        @(posedge clk) disable iff (!rst_n)
        (cyc_end && !fault_seen && s_q.cfg.decay == 2'h0 && s_q.acc != 8'h0) |=> (s_q.acc == $past(s_q.acc) - 8'h1);
    endproperty
    a_rq3_dec: assert property (p_rq3_dec) else $error("accumulator did not decay"); // RQ3

    property p_rq7_hold;
        @(posedge clk) disable iff (!rst_n)
        (cyc_end && !fault_seen && s_q.clean < decay_len(s_q.cfg.decay)) |=> $stable(s_q.acc);
    endproperty
    a_rq7_hold: assert property (p_rq7_hold) else $error("decay too early"); // RQ7

    property p_rq1_still;
        @(posedge clk) disable iff (!rst_n)
        !cyc_end |=> $stable(s_q.acc);
    endproperty
    a_rq1_still: assert property (p_rq1_still) else $error("accumulator moved mid cycle"); // RQ1

    property p_rq6_raise;
        @(posedge clk) disable iff (!rst_n)
        (!alarm && s_d.acc >= s_q.cfg.upper) |=> alarm;
    endproperty
    a_rq6_raise: assert property (p_rq6_raise) else $error("alarm not raised"); // RQ6

    property p_rq4_clear;
        @(posedge clk) disable iff (!rst_n)
        (alarm && s_d.acc <= s_q.cfg.lower) |=> !alarm;
    endproperty
    a_rq4_clear: assert property (p_rq4_clear) else $error("alarm not cleared"); // RQ4

    property p_rq8_hyst;
        @(posedge clk) disable iff (!rst_n)
        ($rose(alarm) |-> (s_q.acc >= $past(s_q.cfg.upper))) and
        ($fell(alarm) |-> (s_q.acc <= $past(s_q.cfg.lower)));
    endproperty
    a_rq8_hyst: assert property (p_rq8_hyst) else $error("alarm changed between thresholds"); // RQ8

    c_raise: cover property (@(posedge clk) disable iff (!rst_n) $rose(alarm));
    c_clear: cover property (@(posedge clk) disable iff (!rst_n) $fell(alarm));
    c_full:  cover property (@(posedge clk) disable iff (!rst_n) s_q.acc == s_q.cfg.limit && s_q.acc != 8'h0);
    c_irq:   cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));

endmodule : lba_top
